// *** hw/system_tick_pkg.sv ***
package system_tick_pkg;

	// Bus phase of the register slave
	typedef enum logic [0:0] {
		PH_IDLE = 1'b0,
		PH_WR_WAIT = 1'b1
	} bus_phase_e;

	// Address phase held over into the data phase
	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic valid;
	} addr_phase_s;

	// Software controls of the timer
	typedef struct packed {
		logic clksrc;
		logic tickint;
		logic enable;
	} tick_ctrl_s;

endpackage

// *** hw/system_tick_regs.svh ***
`ifndef SYSTEM_TICK_REGS_SVH
`define SYSTEM_TICK_REGS_SVH

// Byte addresses of the register words
`define TICK_CTRL_ADDR 32'hE000E010
`define TICK_RELOAD_ADDR 32'hE000E014
`define TICK_CURRENT_ADDR 32'hE000E018
`define TICK_CALIB_ADDR 32'hE000E01C
`define TICK_IRQ_STATUS_ADDR 32'hE000E020
`define TICK_IRQ_MASK_ADDR 32'hE000E024

// Field positions of the control and status word
`define TICK_CTRL_ENABLE_BIT 0
`define TICK_CTRL_TICKINT_BIT 1
`define TICK_CTRL_CLKSRC_BIT 2
`define TICK_CTRL_FLAG_BIT 16

// Field positions of the calibration word
`define TICK_CALIB_NO_REFERENCE_CLOCK_FLAG_BIT 31
`define TICK_CALIB_SKEW_BIT 30

// Reset and fixed values
`define TICK_CTRL_RESET 3'h0
`define TICK_RELOAD_RESET 24'h000000
`define TICK_CURRENT_RESET 24'h000000
`define TICK_TEN_MS_RELOAD 24'h0009C4
`define TICK_NO_REFERENCE_CLOCK_FLAG_VALUE 1'h0
`define TICK_SKEW_VALUE 1'h0
`define TICK_IRQ_RESET 1'h0

// Counting constants
`define TICK_CNT_WIDTH 24
`define TICK_REF_DIV 32

`endif

// *** hw/system_tick_timer.sv ***
// Summary of operation
// - Enable bit 0 loads reload value then counts down; clear stops.
// - Bit 1 decides whether a zero count pends the tick exception.
// - Bit 2 picks count clock: 0 external reference, 1 core clock.
// - Bit 16 flag sets when counter reached zero since last read.
// - Any read of the control and status word clears the flag, unless a zero is reached in the same cycle.
// - 24-bit reload value is copied into the counter at zero.
// - External reference is the crystal input divided by 32.
// - Any write to current value clears counter and the flag.
// - Calibration word reads ten ms reload plus two clock flags.
`timescale 1ns/1ps
`include "system_tick_regs.svh"

module system_tick_timer
	import system_tick_pkg::*;
#(
	parameter int CNT_W = `TICK_CNT_WIDTH,
	parameter int REF_DIV = `TICK_REF_DIV
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CRYSTAL_INPUT_PIN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	output logic TICK_PEND,
	output logic IRQ
);

	logic rst_meta_r;
	logic rst_sync_n;
	bus_phase_e phase_r;
	addr_phase_s ap_r;
	tick_ctrl_s ctrl_r;
	logic [CNT_W-1:0] reload_r;
	logic [CNT_W-1:0] cur_r;
	logic flag_r;
	logic irq_stat_r;
	logic irq_mask_r;
	logic [31:0] rd_data_r;
	logic [31:0] rd_value;
	logic accept;
	logic rd_accept;
	logic wr_apply;
	logic wr_ctrl;
	logic wr_reload;
	logic cur_clr;
	logic wr_stat;
	logic wr_mask;
	logic rd_ctrl;
	logic en_rise;
	logic ref_tick;
	logic count_tick;
	logic zero_evt;

	// Reset is released through two flops; the rest uses the copy
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n <= rst_meta_r;
		end
	end

	// External reference tick from the crystal input
	tick_ref_divider #(
		.DIV(REF_DIV)
	) u_ref_div (
		.clk(CORE_CLK),
		.rst_n(rst_sync_n),
		.crystal_input_pin(CRYSTAL_INPUT_PIN),
		.ref_tick(ref_tick)
	);

	// Bus decode; only whole-word single transfers are expected
	assign accept = HSEL & HTRANS[1] & HREADY;
	assign rd_accept = accept & ~HWRITE;
	assign wr_apply = (phase_r == PH_WR_WAIT) & ap_r.valid & ap_r.write;
	assign wr_ctrl = wr_apply & (ap_r.addr == `TICK_CTRL_ADDR);
	assign wr_reload = wr_apply & (ap_r.addr == `TICK_RELOAD_ADDR);
	assign cur_clr = wr_apply & (ap_r.addr == `TICK_CURRENT_ADDR);
	assign wr_stat = wr_apply & (ap_r.addr == `TICK_IRQ_STATUS_ADDR);
	assign wr_mask = wr_apply & (ap_r.addr == `TICK_IRQ_MASK_ADDR);
	assign rd_ctrl = rd_accept & (HADDR == `TICK_CTRL_ADDR);

	// A write holds one wait state so a following read sees its effect
	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			phase_r <= PH_IDLE;
			ap_r <= '0;
		end else begin
			case (phase_r)
				PH_IDLE: begin
					if (accept && HWRITE) begin
						phase_r <= PH_WR_WAIT;
						ap_r.addr <= HADDR;
						ap_r.write <= 1'b1;
						ap_r.valid <= 1'b1;
					end
				end
				PH_WR_WAIT: begin
					phase_r <= PH_IDLE;
					ap_r.valid <= 1'b0;
				end
				default: begin
					phase_r <= PH_IDLE;
					ap_r.valid <= 1'b0;
				end
			endcase
		end
	end

	assign HREADYOUT = (phase_r != PH_WR_WAIT);
	assign HRESP = 1'b0;

	// Read mux; unmapped words read as zero
	always_comb begin
		rd_value = 32'h00000000;
		if (HADDR == `TICK_CTRL_ADDR) begin
			rd_value[`TICK_CTRL_ENABLE_BIT] = ctrl_r.enable;
			rd_value[`TICK_CTRL_TICKINT_BIT] = ctrl_r.tickint;
			rd_value[`TICK_CTRL_CLKSRC_BIT] = ctrl_r.clksrc;
			rd_value[`TICK_CTRL_FLAG_BIT] = flag_r;
		end else if (HADDR == `TICK_RELOAD_ADDR) begin
			rd_value[CNT_W-1:0] = reload_r;
		end else if (HADDR == `TICK_CURRENT_ADDR) begin
			rd_value[CNT_W-1:0] = cur_r;
		end else if (HADDR == `TICK_CALIB_ADDR) begin
			rd_value[23:0] = `TICK_TEN_MS_RELOAD;
			rd_value[`TICK_CALIB_NO_REFERENCE_CLOCK_FLAG_BIT] = `TICK_NO_REFERENCE_CLOCK_FLAG_VALUE;
			rd_value[`TICK_CALIB_SKEW_BIT] = `TICK_SKEW_VALUE;
		end else if (HADDR == `TICK_IRQ_STATUS_ADDR) begin
			rd_value[0] = irq_stat_r;
		end else if (HADDR == `TICK_IRQ_MASK_ADDR) begin
			rd_value[0] = irq_mask_r;
		end
	end

	// Read data is captured at the address edge and held for the data phase
	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_data_r <= 32'h00000000;
		end else if (rd_accept) begin
			rd_data_r <= rd_value;
		end
	end

	assign HRDATA = rd_data_r;

	// Software controls
	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_r <= `TICK_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r.enable <= HWDATA[`TICK_CTRL_ENABLE_BIT];
			ctrl_r.tickint <= HWDATA[`TICK_CTRL_TICKINT_BIT];
			ctrl_r.clksrc <= HWDATA[`TICK_CTRL_CLKSRC_BIT];
		end
	end

	// Reload value keeps the low 24 bits only
	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reload_r <= `TICK_RELOAD_RESET;
		end else if (wr_reload) begin
			reload_r <= HWDATA[CNT_W-1:0];
		end
	end

	// Count edges come every core cycle or on each reference pulse
	assign count_tick = ctrl_r.clksrc ? 1'b1 : ref_tick;
	assign en_rise = wr_ctrl & HWDATA[`TICK_CTRL_ENABLE_BIT] & ~ctrl_r.enable;
	// Zero is reached on the step from one; a zero reload never fires
	assign zero_evt = ctrl_r.enable & count_tick & (cur_r == CNT_W'(1)) &
		~cur_clr;

	// Down counter; a current write or an enabling control write beats a count edge in the same cycle
	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur_r <= `TICK_CURRENT_RESET;
		end else if (cur_clr) begin
			cur_r <= '0;
		end else if (en_rise) begin
			cur_r <= reload_r;
		end else if (ctrl_r.enable && count_tick) begin
			if (cur_r == '0) begin
				cur_r <= reload_r;
			end else begin
				cur_r <= cur_r - 1'b1;
			end
		end
	end

	// Zero flag; a new zero in the clearing cycle is kept
	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flag_r <= 1'b0;
		end else if (zero_evt) begin
			flag_r <= 1'b1;
		end else if (rd_ctrl || cur_clr) begin
			flag_r <= 1'b0;
		end
	end

	// Exception pend pulse, gated by the pend enable
	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			TICK_PEND <= 1'b0;
		end else begin
			TICK_PEND <= zero_evt & ctrl_r.tickint;
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_stat_r <= `TICK_IRQ_RESET;
		end else if (zero_evt) begin
			irq_stat_r <= 1'b1;
		end else if (wr_stat && HWDATA[0]) begin
			irq_stat_r <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_mask_r <= `TICK_IRQ_RESET;
		end else if (wr_mask) begin
			irq_mask_r <= HWDATA[0];
		end
	end

	assign IRQ = irq_stat_r & irq_mask_r;

	// Checks on counter, flag, pend and bus read-back
	a_enable_load: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		$rose(ctrl_r.enable) |-> cur_r == $past(reload_r))
		else $error("enable did not load the reload value");

	a_stop_hold: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		(!ctrl_r.enable && !wr_apply) |=> $stable(cur_r))
		else $error("counter moved while stopped");

	a_pend_gate: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		zero_evt |=> TICK_PEND == $past(ctrl_r.tickint))
		else $error("pend pulse does not follow pend enable");

	// A pend pulse without a zero event would raise a stray exception
	a_pend_cause: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		!zero_evt |=> !TICK_PEND)
		else $error("pend pulse without a zero event");

	a_ext_hold: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		(ctrl_r.enable && !ctrl_r.clksrc && !ref_tick && !wr_apply)
		|=> $stable(cur_r))
		else $error("counter moved without a reference pulse");

	a_flag_set: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		zero_evt |=> flag_r && cur_r == '0)
		else $error("zero reached but flag not set");

	// Sticky: only a control read or a current write may drop the flag
	a_flag_hold: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		(flag_r && !rd_ctrl && !cur_clr) |=> flag_r)
		else $error("zero flag dropped on its own");

	a_flag_cause: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		(!flag_r && !zero_evt) |=> !flag_r)
		else $error("zero flag set without a zero event");

	a_read_clear: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		(rd_ctrl && !zero_evt) |=> !flag_r)
		else $error("control read did not clear the flag");

	// The read must still report the flag that it clears
	a_flag_readback: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		rd_ctrl |=> HRDATA[`TICK_CTRL_FLAG_BIT] == $past(flag_r))
		else $error("control read lost the zero flag");

	a_zero_reload: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		(ctrl_r.enable && count_tick && cur_r == '0 && !wr_apply)
		|=> cur_r == $past(reload_r))
		else $error("counter did not reload at zero");

	a_reload_write: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		wr_reload |=> reload_r == $past(HWDATA[CNT_W-1:0]))
		else $error("reload value not taken from the write");

	a_cur_clear: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		cur_clr |=> cur_r == '0 && !flag_r)
		else $error("current write did not clear counter and flag");

	a_calib_read: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		(rd_accept && HADDR == `TICK_CALIB_ADDR)
		|=> HRDATA == 32'h000009C4)
		else $error("calibration word wrong");

	a_count_step: assert property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		(ctrl_r.enable && count_tick && cur_r != '0 && !wr_apply)
		|=> cur_r == $past(cur_r) - 1'b1)
		else $error("counter did not step down by one");

	c_cur_clear: cover property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n) cur_clr && flag_r);

	c_zero_evt: cover property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n) zero_evt);

	c_irq_rise: cover property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n) $rose(IRQ));

	c_flag_read: cover property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n) rd_ctrl && flag_r);

	c_ext_step: cover property (@(posedge CORE_CLK)
		disable iff (!rst_sync_n)
		ctrl_r.enable && !ctrl_r.clksrc && ref_tick && cur_r != '0);

endmodule

// *** hw/tick_ref_divider.sv ***
`timescale 1ns/1ps
`include "system_tick_regs.svh"

module tick_ref_divider
	import system_tick_pkg::*;
#(
	parameter int DIV = `TICK_REF_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic crystal_input_pin,
	output logic ref_tick
);

	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	localparam int GW = W + 2;
	// Rises are two core cycles apart at best, DIV of them per pulse
	localparam logic [GW-1:0] GAP = GW'(2 * DIV - 1);

	logic xin_d_r;
	logic [W-1:0] cnt_r;
	logic rise;
	logic [GW-1:0] gap_r;

	// Rising edges of the crystal input, sampled on the core clock
	assign rise = crystal_input_pin & ~xin_d_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xin_d_r <= 1'b0;
		end else begin
			xin_d_r <= crystal_input_pin;
		end
	end

	// One pulse for every DIV rising crystal edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			ref_tick <= 1'b0;
		end else begin
			ref_tick <= 1'b0;
			if (rise) begin
				if (cnt_r == LAST) begin
					cnt_r <= '0;
					ref_tick <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
	end

	// Cycles since the last pulse; saturates, so any DIV fits the check
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_r <= '1;
		end else if (ref_tick) begin
			gap_r <= '0;
		end else if (gap_r != '1) begin
			gap_r <= gap_r + 1'b1;
		end
	end

	// Each crystal edge needs two core cycles, so pulses lie far apart
	a_div_spacing: assert property (@(posedge clk)
		disable iff (!rst_n)
		ref_tick |-> gap_r >= GAP)
		else $error("reference tick pulses too close");

	a_div_cause: assert property (@(posedge clk)
		disable iff (!rst_n)
		ref_tick |-> $past(rise) && cnt_r == '0)
		else $error("reference tick without a full divide");

endmodule

// *** verification/system_tick_timer_bench.sv ***
`timescale 1ns/1ps
`include "system_tick_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
	$display("FAIL %0t got %h expected %h", $time, g, e); end end

module system_tick_timer_bench
	import system_tick_pkg::*;
;
	localparam int DIV = `TICK_REF_DIV;
	logic clk = 0, rst_n = 0, xtal = 0, xtal_run = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata_s, q, d;
	logic hreadyout, hresp, tick_pend, irq, rdy_s;
	logic [31:0] seed = 32'h41DF6621;
	int mismatches = 0, tests_run = 0, p, n, k, waits;

	always #12.5 clk = ~clk;
	// Bus answers settle mid-cycle; capture them where no edge races them
	always @(negedge clk) begin
		rdy_s = hreadyout;
		rdata_s = hrdata;
	end
	// Crystal toggles each core cycle, so one rise every two cycles
	always @(posedge clk) if (xtal_run) xtal <= ~xtal;

	system_tick_timer #(.REF_DIV(DIV)) uut (.CORE_CLK(clk), .RST_N(rst_n),
		.CRYSTAL_INPUT_PIN(xtal), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata),
		.HRESP(hresp), .TICK_PEND(tick_pend), .IRQ(irq));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Pend period in core cycles; the crystal rises every two cycles
	function int exp_period(input logic core, input int rl);
		return core ? rl + 1 : 2 * DIV * (rl + 1);
	endfunction

	task end_of_test;
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One single transfer; waits on the slave's ready in both phases
	task bus(input logic w, input logic [31:0] a, dat,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (rdy_s !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= dat;
		waits = 0;
		@(posedge clk);
		while (rdy_s !== 1'b1) begin
			@(posedge clk);
			waits++;
		end
		r = rdata_s;
	endtask

	task wr(input logic [31:0] a, dat);
		logic [31:0] r;
		bus(1'b1, a, dat, r);
		`CHK(waits, 1)
	endtask

	task chk_rd(input logic [31:0] a, e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		`CHK(r, e)
		`CHK(waits, 0)
	endtask

	// Cycles between two pend pulses; bounded so a dead timer cannot hang
	task period(output int c);
		int w;
		w = 0;
		c = 0;
		@(negedge clk);
		while (tick_pend !== 1'b1 && w < 4000) begin
			@(negedge clk);
			w++;
		end
		do begin
			@(negedge clk);
			c++;
		end while (tick_pend !== 1'b1 && c < 4000);
	endtask

	task chk_irq(input logic e);
		@(negedge clk);
		`CHK(irq, e)
	endtask

	initial begin
		fork
			begin
				repeat (20000) @(posedge clk);
				mismatches++;
				end_of_test();
			end
		join_none
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset state and fixed words, unmapped place
		chk_rd(`TICK_CTRL_ADDR, 32'h0);
		chk_rd(`TICK_CALIB_ADDR, 32'h000009C4);
		wr(`TICK_CALIB_ADDR, rnd());
		chk_rd(`TICK_CALIB_ADDR, 32'h000009C4);
		wr(32'hE000E030, rnd());
		chk_rd(32'hE000E030, 32'h0);
		chk_rd(`TICK_IRQ_STATUS_ADDR, 32'h0);
		chk_rd(`TICK_IRQ_MASK_ADDR, 32'h0);
		// Reload holds 24 bits only
		d = rnd();
		wr(`TICK_RELOAD_ADDR, d);
		chk_rd(`TICK_RELOAD_ADDR, d & 32'h00FFFFFF);
		wr(`TICK_CURRENT_ADDR, rnd());
		chk_rd(`TICK_CURRENT_ADDR, 32'h0);
		// Enable on the idle external clock: load, then no counting
		wr(`TICK_CTRL_ADDR, 32'h1);
		chk_rd(`TICK_CURRENT_ADDR, d & 32'h00FFFFFF);
		repeat (20) @(posedge clk);
		chk_rd(`TICK_CURRENT_ADDR, d & 32'h00FFFFFF);
		wr(`TICK_CTRL_ADDR, 32'h0);
		// Core clock periods; reload of one is the shortest corner
		for (int i = 0; i < 4; i++) begin
			n = (i == 0) ? 1 : 3 + int'(rnd() % 12);
			wr(`TICK_RELOAD_ADDR, n);
			wr(`TICK_CTRL_ADDR, 32'h7);
			period(p);
			`CHK(p, exp_period(1'b1, n))
			wr(`TICK_CTRL_ADDR, 32'h0);
		end
		// External reference: one count per DIV crystal rises
		xtal_run <= 1'b1;
		n = 5;
		wr(`TICK_RELOAD_ADDR, n);
		wr(`TICK_CTRL_ADDR, 32'h3);
		period(p);
		`CHK(p, exp_period(1'b0, n))
		// Pend disabled: zeros pass silently, flag still records them
		chk_rd(`TICK_CTRL_ADDR, 32'h00010003);
		wr(`TICK_CTRL_ADDR, 32'h5);
		k = 0;
		repeat (40) begin
			@(negedge clk);
			if (tick_pend === 1'b1) k++;
		end
		`CHK(k, 0)
		wr(`TICK_CTRL_ADDR, 32'h4);
		chk_rd(`TICK_CTRL_ADDR, 32'h00010004);
		chk_rd(`TICK_CTRL_ADDR, 32'h00000004);
		// A current write clears a standing flag
		wr(`TICK_CTRL_ADDR, 32'h5);
		repeat (20) @(posedge clk);
		wr(`TICK_CTRL_ADDR, 32'h4);
		wr(`TICK_CURRENT_ADDR, rnd());
		chk_rd(`TICK_CTRL_ADDR, 32'h00000004);
		chk_rd(`TICK_CURRENT_ADDR, 32'h0);
		// Interrupt: raise, mask, unmask, clear by writing one
		chk_rd(`TICK_IRQ_STATUS_ADDR, 32'h1);
		chk_irq(1'b0);
		wr(`TICK_IRQ_MASK_ADDR, 32'h1);
		chk_irq(1'b1);
		wr(`TICK_IRQ_MASK_ADDR, 32'h0);
		chk_irq(1'b0);
		wr(`TICK_IRQ_MASK_ADDR, 32'h1);
		wr(`TICK_IRQ_STATUS_ADDR, 32'h1);
		chk_irq(1'b0);
		chk_rd(`TICK_IRQ_STATUS_ADDR, 32'h0);
		wr(`TICK_CTRL_ADDR, 32'h5);
		repeat (20) @(posedge clk);
		chk_irq(1'b1);
		`CHK(hresp, 1'b0)
		// Reset in mid-run returns the controls to zero
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk_rd(`TICK_CTRL_ADDR, 32'h0);
		chk_irq(1'b0);
		end_of_test();
	end
endmodule
